// ===== verilog/upc_cfg.svh
/*
 Offsets, field positions, masks and codes of the packet capture and
 PHY control register block.
 Assumes inclusion by the design modules only.
*/
`ifndef UPC_CFG_SVH
`define UPC_CFG_SVH

// Register byte offsets
`define UPC_OFF_PID 8'h2C
`define UPC_OFF_EP 8'h30
`define UPC_OFF_TAG 8'h34
`define UPC_OFF_OTGM 8'h38
`define UPC_OFF_PWR 8'h3C
`define UPC_OFF_PHY 8'h40
`define UPC_OFF_IRQ_ST 8'h44
`define UPC_OFF_IRQ_MASK 8'h48

// Field positions
`define UPC_EP_VALID_BIT 4
`define UPC_PWR_WIDTH 9
`define UPC_PHY_PD_BIT 18
`define UPC_PHY_SE0_BIT 13
`define UPC_PHY_K_BIT 12
`define UPC_PHY_FLT_HI 11
`define UPC_PHY_FLT_LO 8
`define UPC_PHY_AUTO_BIT 7
`define UPC_PHY_CONF_HI 6
`define UPC_PHY_CONF_LO 4
// Writable bits of the PHY control word
`define UPC_PHY_RW_MASK 32'h00043FF0

// Endpoint tag ORed into the receive port
`define UPC_EP_TAG 5'h10

// Interrupt status bits
`define UPC_IRQ_PKT 0
`define UPC_IRQ_SE0 1
`define UPC_IRQ_K 2
`define UPC_IRQ_LS 3
`define UPC_IRQ_W 4

// Line states
`define UPC_LS_SE0 2'h0
`define UPC_LS_J 2'h1
`define UPC_LS_K 2'h2

`endif

// ===== verilog/upc_pkg.sv
/*
 Types shared by the capture and PHY control block.
 Assumes the configuration header is on the include path.
*/
package upc_pkg;
	typedef logic [31:0] upc_word_t;
	typedef logic [1:0] upc_ls_t;
	typedef enum logic [1:0] {UPC_AWAKE, UPC_SUSPENDED} upc_susp_t;
endpackage : upc_pkg

// ===== verilog/upc_sync3.sv
/*
 Three-flop input synchroniser with agreement check on a bus.
 Assumes the input is asynchronous to MCLK.
*/
`timescale 1ns/1ps
module upc_sync3 #(
	parameter int W = 2,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	wire agree = (s2_reg == s3_reg);

	// Change counts only once stages two and three agree
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// Reset to the pin's idle level, so no false change follows reset
			s1_reg <= INIT;
			s2_reg <= INIT;
			s3_reg <= INIT;
			q <= INIT;
		end
		else
		begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (agree)
				q <= s3_reg;
		end
	end
endmodule : upc_sync3

// ===== verilog/upc_ls_filter.sv
/*
 Line state filter: a new line state passes only after it has held
 for one clock cycle more than two to the power of the shift value.
 Assumes a synchronised line state input.
*/
`timescale 1ns/1ps
`include "upc_cfg.svh"
module upc_ls_filter
	import upc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] shift,
	input wire upc_pkg::upc_ls_t ls_in,
	output upc_pkg::upc_ls_t ls_out,
	output logic changed
);
	logic [15:0] cnt_reg;
	upc_ls_t cand_reg;
	wire [15:0] limit = 16'(16'h0001 << shift);
	wire differs = (ls_in != ls_out);
	wire restart = (ls_in != cand_reg);
	wire expire = differs && !restart && ((cnt_reg + 16'h0001) >= limit);

	// R8: hold-off before propagating
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg <= 16'h0000;
			cand_reg <= `UPC_LS_J;
			ls_out <= `UPC_LS_J;
			changed <= 1'b0;
		end
		else
		begin
			cand_reg <= ls_in;
			changed <= expire;
			if (!differs || restart)
				cnt_reg <= 16'h0000;
			else if (expire)
			begin
				cnt_reg <= 16'h0000;
				ls_out <= ls_in;
			end
			else
				cnt_reg <= cnt_reg + 16'h0001;
		end
	end
endmodule : upc_ls_filter

// ===== verilog/upc_top.sv
/*
 USB packet capture and PHY control registers: last PID and endpoint,
 endpoint tag mask, flag mask, power signalling value, PHY control with
 line state filter and hardware auto-resume, plus an interrupt unit.
 Assumes an Avalon-MM master on MCLK and packet strobes from the
 receive logic on MCLK; the PHY line state arrives asynchronously.

// How it works
// R1: Latch each received PID, read-only
// R2: Latch last endpoint number, read-only
// R3: Endpoint valid bit after first capture
// R4: Masked endpoints get 0x10 on receive port
// R5: Bit 18 disables wide port pulldowns
// R6: SE0 auto-resume sets bit 13, write-0 clears
// R7: K auto-resume sets bit 12, write-0 clears
// R8: Linestate change waits two-power-n clocks
// R9: Bit 7 enables hardware resume from suspend
// R10: Bits 6:4 drive PHY config pins
// R11: Reserved bits read zero, ignore writes
*/
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`include "upc_cfg.svh"
module upc_top
	import upc_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output upc_pkg::upc_word_t AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic [1:0] AVS_RESPONSE,
	input wire logic RX_PKT_VALID,
	input wire logic [3:0] RX_PKT_PID,
	input wire logic [3:0] RX_PKT_EP,
	output logic [4:0] RX_PORT_EP,
	output logic RX_PORT_VALID,
	input wire logic [1:0] PHY_LINESTATE,
	input wire logic SUSPEND_REQ,
	output logic [1:0] LINESTATE_FILT,
	output logic SUSPENDED,
	output logic RESUME_PULSE,
	output logic WIDE_PORT_A_PD_DIS,
	output logic WIDE_PORT_B_PD_DIS,
	output logic [2:0] PHY_CONFIG_PINS,
	output logic IRQ
);
	logic [3:0] pid_reg;
	logic [3:0] ep_reg;
	logic ep_valid_reg;
	logic [15:0] tag_mask_reg;
	upc_word_t otg_mask_reg;
	logic [`UPC_PWR_WIDTH-1:0] pwr_reg;
	upc_word_t phy_reg;
	logic [`UPC_IRQ_W-1:0] irq_st_reg;
	logic [`UPC_IRQ_W-1:0] irq_mask_reg;
	logic ack_reg;
	upc_susp_t susp_reg;
	upc_ls_t ls_sync;
	upc_ls_t ls_filt;
	logic ls_changed;

	// Bus decode: one wait state, answer on the second edge
	wire req = (AVS_READ || AVS_WRITE) && !ack_reg;
	wire wr_go = AVS_WRITE && ack_reg;
	wire hit_pid = (AVS_ADDRESS == `UPC_OFF_PID);
	wire hit_ep = (AVS_ADDRESS == `UPC_OFF_EP);
	wire hit_tag = (AVS_ADDRESS == `UPC_OFF_TAG);
	wire hit_otg = (AVS_ADDRESS == `UPC_OFF_OTGM);
	wire hit_pwr = (AVS_ADDRESS == `UPC_OFF_PWR);
	wire hit_phy = (AVS_ADDRESS == `UPC_OFF_PHY);
	wire hit_ist = (AVS_ADDRESS == `UPC_OFF_IRQ_ST);
	wire hit_imk = (AVS_ADDRESS == `UPC_OFF_IRQ_MASK);
	wire hit_any = hit_pid | hit_ep | hit_tag | hit_otg | hit_pwr | hit_phy | hit_ist | hit_imk;
	wire [31:0] be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
		{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
	wire [31:0] wmask = be_mask & {32{wr_go}};
	wire [31:0] wdat = AVS_WRITEDATA;

	// R11: only documented fields assemble into read data
	wire [31:0] rd_mux = hit_pid ? {28'h0000000, pid_reg} :
		hit_ep ? {27'h0000000, ep_valid_reg, ep_reg} :
		hit_tag ? {16'h0000, tag_mask_reg} :
		hit_otg ? otg_mask_reg :
		hit_pwr ? {23'h000000, pwr_reg} :
		hit_phy ? (phy_reg & `UPC_PHY_RW_MASK) :
		hit_ist ? {28'h0000000, irq_st_reg} :
		hit_imk ? {28'h0000000, irq_mask_reg} : 32'h00000000;

	// Hold-off exponent for the line state filter
	wire [3:0] flt_shift = phy_reg[`UPC_PHY_FLT_HI:`UPC_PHY_FLT_LO];

	// Auto-resume events, only while suspended and enabled
	// A line change while awake is only a status event
	wire auto_en = phy_reg[`UPC_PHY_AUTO_BIT];
	wire in_susp = (susp_reg == UPC_SUSPENDED);
	wire res_se0 = in_susp && auto_en && ls_changed && (ls_filt == `UPC_LS_SE0);
	wire res_k = in_susp && auto_en && ls_changed && (ls_filt == `UPC_LS_K);

	// R8: line state through synchroniser then hold-off filter
	upc_sync3 #(
		.W(2),
		.INIT(`UPC_LS_J)
	) u_sync (
		.clk(MCLK),
		.rst_n(RESET_N),
		.d(PHY_LINESTATE),
		.q(ls_sync)
	);

	upc_ls_filter u_filt (
		.clk(MCLK),
		.rst_n(RESET_N),
		.shift(flt_shift),
		.ls_in(ls_sync),
		.ls_out(ls_filt),
		.changed(ls_changed)
	);

	// Read data and response settle at the request edge, stand until the next
	wire [31:0] rdata_next = AVS_READ ? rd_mux : 32'h00000000;
	wire [1:0] resp_next = hit_any ? 2'h0 : 2'h2;

	// One wait state: acknowledge follows the first request cycle
	// Holding the request past the acknowledge starts a new transfer
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			ack_reg <= 1'b0;
		else
			ack_reg <= req;
	end

	// Bus handshake; waitrequest drops in the acknowledge cycle
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			AVS_READDATA <= 32'h00000000;
			AVS_RESPONSE <= 2'h0;
		end
		else if (req)
		begin
			AVS_READDATA <= rdata_next;
			AVS_RESPONSE <= resp_next;
		end
	end

	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_reg;

	// R1 R2 R3: capture of the last received packet
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			pid_reg <= 4'h0;
			ep_reg <= 4'h0;
			ep_valid_reg <= 1'b0;
		end
		else if (RX_PKT_VALID)
		begin
			// R1: latch PID
			pid_reg <= RX_PKT_PID;
			// R2: latch endpoint
			ep_reg <= RX_PKT_EP;
			// R3: endpoint now valid
			ep_valid_reg <= 1'b1;
		end
	end

	// Tag bit of the arriving endpoint; untagged endpoints pass unchanged
	wire pkt_tagged = tag_mask_reg[RX_PKT_EP];
	wire [4:0] port_ep_next = {1'b0, RX_PKT_EP} | (pkt_tagged ? `UPC_EP_TAG : 5'h00);

	// R4: tagged endpoint onto the receive port
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			RX_PORT_EP <= 5'h00;
			RX_PORT_VALID <= 1'b0;
		end
		else
		begin
			RX_PORT_VALID <= RX_PKT_VALID;
			if (RX_PKT_VALID)
				RX_PORT_EP <= port_ep_next;
		end
	end

	// Lane write masks per register; a miss writes nothing
	// Reserved upper bits never reach a register
	wire [15:0] tag_wr = hit_tag ? wmask[15:0] : 16'h0000;
	wire [31:0] otg_wr = hit_otg ? wmask : 32'h00000000;
	wire [8:0] pwr_wr = hit_pwr ? wmask[8:0] : 9'h000;
	wire [3:0] imk_wr = hit_imk ? wmask[3:0] : 4'h0;

	// R4: mask writable
	wire [15:0] tag_mask_next = (tag_mask_reg & ~tag_wr) | (wdat[15:0] & tag_wr);
	wire [31:0] otg_mask_next = (otg_mask_reg & ~otg_wr) | (wdat & otg_wr);
	wire [`UPC_PWR_WIDTH-1:0] pwr_next = (pwr_reg & ~pwr_wr) | (wdat[8:0] & pwr_wr);
	wire [`UPC_IRQ_W-1:0] irq_mask_next = (irq_mask_reg & ~imk_wr) | (wdat[3:0] & imk_wr);

	// Endpoint tag mask
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			tag_mask_reg <= 16'h0000;
		else
			tag_mask_reg <= tag_mask_next;
	end

	// Flag mask, all bits kept for software
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			otg_mask_reg <= 32'h00000000;
		else
			otg_mask_reg <= otg_mask_next;
	end

	// Power signalling value and its valid bit
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			pwr_reg <= 9'h000;
		else
			pwr_reg <= pwr_next;
	end

	// Interrupt mask
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			irq_mask_reg <= 4'h0;
		else
			irq_mask_reg <= irq_mask_next;
	end

	// PHY control: hardware set of the resume cause wins over a clear
	wire [31:0] phy_wr = (hit_phy ? wmask : 32'h00000000) & `UPC_PHY_RW_MASK;
	wire [31:0] phy_base = (phy_reg & ~phy_wr) | (wdat & phy_wr);
	wire [31:0] phy_next = phy_base | ({31'h00000000, res_se0} << `UPC_PHY_SE0_BIT)
		| ({31'h00000000, res_k} << `UPC_PHY_K_BIT);

	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			phy_reg <= 32'h00000000;
		else
			// R6 R7: sticky resume causes; R11: reserved ignored
			phy_reg <= phy_next;
	end

	// R9: suspend controller, active only with auto-resume enabled
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			susp_reg <= UPC_AWAKE;
		else
		begin
			case (susp_reg)
				UPC_AWAKE:
					if (SUSPEND_REQ && auto_en)
						susp_reg <= UPC_SUSPENDED;
				UPC_SUSPENDED:
					if (res_se0 || res_k || !auto_en)
						susp_reg <= UPC_AWAKE;
				default:
					susp_reg <= UPC_AWAKE;
			endcase
		end
	end

	// Interrupt status: write one to clear, set wins
	wire [3:0] irq_ev = {ls_changed, res_k, res_se0, RX_PKT_VALID};
	wire [3:0] irq_clr = hit_ist ? (wdat[3:0] & wmask[3:0]) : 4'h0;
	wire [3:0] irq_st_next = (irq_st_reg & ~irq_clr) | irq_ev;

	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			irq_st_reg <= 4'h0;
		else
			irq_st_reg <= irq_st_next;
	end

	// PHY control fields that leave the block
	wire pd_dis = phy_reg[`UPC_PHY_PD_BIT];
	wire [2:0] conf_bits = phy_reg[`UPC_PHY_CONF_HI:`UPC_PHY_CONF_LO];

	// R5: pulldown disable; R10: config pins from register
	assign WIDE_PORT_A_PD_DIS = pd_dis;
	assign WIDE_PORT_B_PD_DIS = pd_dis;
	assign PHY_CONFIG_PINS = conf_bits;
	// R9: software polls the filtered line state otherwise
	assign LINESTATE_FILT = ls_filt;
	assign SUSPENDED = in_susp;
	assign RESUME_PULSE = res_se0 || res_k;
	assign IRQ = |(irq_st_reg & irq_mask_reg);
endmodule : upc_top

// ===== test/upc_checker.sv
/*
 Port checker for the packet capture and PHY control block.
 Assumes a bind to upc_top and one clock domain, MCLK.
*/
`timescale 1ns/1ps
module upc_checker (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire upc_pkg::upc_word_t AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic RX_PKT_VALID,
	input wire logic [3:0] RX_PKT_EP,
	input wire logic [4:0] RX_PORT_EP,
	input wire logic RX_PORT_VALID,
	input wire logic [1:0] PHY_LINESTATE,
	input wire logic [1:0] LINESTATE_FILT,
	input wire logic WIDE_PORT_A_PD_DIS,
	input wire logic WIDE_PORT_B_PD_DIS,
	input wire logic [2:0] PHY_CONFIG_PINS,
	input wire logic SUSPENDED,
	input wire logic RESUME_PULSE
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RESET_N);
	// Accepted read, accepted PHY control write
	wire acc = AVS_READ && !AVS_WAITREQUEST;
	wire phw = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h40 && AVS_BYTEENABLE == 4'hF;
	chk_port_valid: assert property (RX_PKT_VALID |=> RX_PORT_VALID)
		else $error("receive port pulse missing");
	chk_port_ep: assert property (RX_PKT_VALID |=> RX_PORT_EP[3:0] == $past(RX_PKT_EP))
		else $error("receive port endpoint wrong");
	chk_pid_rsvd: assert property (acc && AVS_ADDRESS == 8'h2C |-> AVS_READDATA[31:4] == 28'h0)
		else $error("pid upper bits set");
	chk_ep_rsvd: assert property (acc && AVS_ADDRESS == 8'h30 |-> AVS_READDATA[31:5] == 27'h0)
		else $error("endpoint upper bits set");
	chk_unmapped_zero: assert property (acc && AVS_ADDRESS == 8'h00 |-> AVS_READDATA == 32'h0)
		else $error("unmapped read not zero");
	chk_pd_write: assert property (phw |=> WIDE_PORT_A_PD_DIS == $past(AVS_WRITEDATA[18])
		&& WIDE_PORT_B_PD_DIS == WIDE_PORT_A_PD_DIS)
		else $error("pulldown disable wrong");
	chk_cfg_write: assert property (phw |=> PHY_CONFIG_PINS == $past(AVS_WRITEDATA[6:4]))
		else $error("config pins wrong");
	// Filtered state can only take a value already past the synchroniser
	chk_filt_lag: assert property ($changed(LINESTATE_FILT) |-> LINESTATE_FILT == $past(PHY_LINESTATE, 3))
		else $error("line state passed too early");
	cover property (RX_PORT_VALID && RX_PORT_EP[4]);
	cover property (phw);
	cover property ($changed(LINESTATE_FILT));
	// a resume event wakes the suspend controller on the next edge
	chk_resume_wake: assert property (RESUME_PULSE |-> SUSPENDED ##1 !SUSPENDED)
		else $error("resume did not leave suspend");
	cover property (RESUME_PULSE);
endmodule : upc_checker
bind upc_top upc_checker u_chk (.*);

// ===== test/upc_phy_model.sv
/*
 Line side model: host idle, resume and reset signalling.
 Assumes the bench calls drive after a clock edge.
*/
`timescale 1ns/1ps
module upc_phy_model (
	input wire logic clk,
	output logic [1:0] line_state
);
	// Bus idles in J after attach
	initial line_state = 2'h1;
	// host signals K resume or SE0 reset
	task automatic drive(input logic [1:0] s);
		@(posedge clk);
		line_state <= s;
	endtask : drive
endmodule : upc_phy_model

// ===== test/upc_top_test.sv
/*
 Self-checking bench for the capture and PHY control block.
 Assumes the line model and the checker bound to the top.
*/
`timescale 1ns/1ps
module upc_top_test;
	logic clk = 0;
	logic rst_n = 0;
	logic [7:0] addr = 0;
	logic rd = 0;
	logic wr = 0;
	logic [31:0] wdata = 0;
	logic pkv = 0;
	logic [3:0] pid = 0;
	logic [3:0] ep = 0;
	logic sreq = 0;
	logic [31:0] rdata;
	logic wt, pv, sus, irq, pda, pdb;
	logic [4:0] pep;
	logic [2:0] cfg;
	logic [1:0] ls, filt;
	int err_total = 0;
	int compares = 0;
	int seed = 23417;
	logic [31:0] rq[$];
	logic [4:0] eq[$];
	logic [15:0] tm = 0;
	logic [3:0] be = 4'hF;
	logic [1:0] resp;
	logic rp;
	int rp_cnt = 0;
	upc_top dut (.MCLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wt),
		.AVS_RESPONSE(resp), .RX_PKT_VALID(pkv), .RX_PKT_PID(pid), .RX_PKT_EP(ep), .RX_PORT_EP(pep),
		.RX_PORT_VALID(pv), .PHY_LINESTATE(ls), .SUSPEND_REQ(sreq), .LINESTATE_FILT(filt),
		.SUSPENDED(sus), .RESUME_PULSE(rp), .WIDE_PORT_A_PD_DIS(pda), .WIDE_PORT_B_PD_DIS(pdb),
		.PHY_CONFIG_PINS(cfg), .IRQ(irq));
	upc_phy_model u_phy (.clk(clk), .line_state(ls));
	initial
		forever #2.5 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict;
		$display("compares %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	// Read notes only; the monitor settles them at the accepting edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		if (!w)
			rq.push_back(d);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		do
			@(posedge clk);
		while (wt !== 1'b0 && ++n < 50);
		if (n >= 50)
		begin
			err_total++;
			$display("unexpected at %0t: no bus answer", $time);
		end
		rd <= 0;
		wr <= 0;
		@(posedge clk);
	endtask : bus
	task automatic pkts(input int k);
		repeat (k)
		begin
			pid <= $random(seed);
			ep <= $random(seed);
			@(posedge clk);
			eq.push_back({tm[ep], ep});
		end
		pkv <= 0;
	endtask : pkts
	// Enter suspend, then let the host signal on the line
	task automatic wake(input logic [1:0] s);
		int n;
		logic [1:0] prev;
		n = 0;
		prev = filt;
		sreq <= 1;
		while (sus !== 1'b1 && ++n < 50)
			@(posedge clk);
		if (n >= 50)
		begin
			err_total++;
			$display("unexpected at %0t: suspend not entered", $time);
		end
		sreq <= 0;
		u_phy.drive(s);
		// Sync and agreement take four edges, then the filter takes 2^2 plus one
		repeat (9) @(posedge clk);
		chk(filt, prev);
		@(posedge clk);
		chk(filt, s);
		repeat (50) @(posedge clk);
	endtask : wake
	// Oldest note against each result
	always @(posedge clk)
	begin
		if (rd && wt === 1'b0)
			chk(rdata, rq.pop_front());
		if (pv === 1'b1)
			chk(pep, eq.pop_front());
		if (rp === 1'b1)
			rp_cnt++;
	end
	initial
	begin
		#20000;
		err_total++;
		print_verdict();
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		for (int a = 8'h2C; a <= 8'h48; a += 4)
			bus(0, a, 0);
		tm = $random(seed);
		bus(1, 8'h34, {16'hFFFF, tm});
		bus(0, 8'h34, {16'h0, tm});
		be <= 4'h2;
		bus(1, 8'h34, 32'h0000FFFF);
		be <= 4'hF;
		tm[15:8] = 8'hFF;
		bus(0, 8'h34, {16'h0, tm});
		bus(1, 8'h38, '1);
		bus(0, 8'h38, '1);
		bus(1, 8'h3C, '1);
		bus(0, 8'h3C, 32'h1FF);
		bus(1, 8'h40, '1);
		bus(0, 8'h40, 32'h43FF0);
		chk({pda, pdb, cfg}, 5'h1F);
		bus(1, 8'h2C, '1);
		bus(0, 8'h00, 0);
		chk(resp, 2'h2);
		bus(1, 8'h40, 32'h200);
		chk(resp, 2'h0);
		chk({pda, cfg}, 0);
		$display("registers done");
		pkv <= 1;
		pkts(8);
		repeat (2) @(posedge clk);
		bus(0, 8'h2C, pid);
		bus(0, 8'h30, {1'b1, ep});
		bus(0, 8'h44, 1);
		bus(1, 8'h44, 1);
		$display("packets done");
		bus(1, 8'h40, 32'h280);
		bus(1, 8'h48, 32'h6);
		wake(2'h2);
		chk(irq, 1);
		bus(0, 8'h40, 32'h1280);
		bus(1, 8'h40, 32'h280);
		bus(0, 8'h40, 32'h280);
		bus(1, 8'h44, 32'hF);
		chk(irq, 0);
		u_phy.drive(2'h1);
		repeat (60) @(posedge clk);
		wake(2'h0);
		bus(0, 8'h40, 32'h2280);
		chk(irq, 1);
		$display("resume done");
		chk(rp_cnt, 2);
		if (rq.size() != 0 || eq.size() != 0)
		begin
			err_total++;
			$display("unexpected at %0t: results left unchecked", $time);
		end
		print_verdict();
	end
endmodule : upc_top_test
